// File: cmp_pkg.sv
// package: register map, field layout, reset values and timing of the comparator block
// Overview of operation
// - result is one when positive input exceeds negative; readable and routable to pin
// - positive input picks one of two pins; negative picks pin or reference
// - after enable, result and change flag are unsettled for 10 us
// - a disabled comparator shows a result of one
// - low result at disable gives a rising edge that sets the change flag
// - reference offers eight levels, each comparator with its own level
// - each config register holds a change flag set on every result change outside the settle time
// - both comparators share one interrupt; software reads both flags
// - comparators stay on in idle and power-down; total power-down disables both
// - unmasked change outside total power-down interrupts and wakes the processor
// - bit 5 of auxiliary power control switches all comparators off
package cmp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned N_CMP  = 2;
  localparam int unsigned REF_W  = 3;

  // register byte offsets
  localparam logic [7:0] CFG0_OFS = 8'h00;
  localparam logic [7:0] CFG1_OFS = 8'h04;
  localparam logic [7:0] REF_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] MASK_OFS = 8'h10;
  localparam logic [7:0] PWR_OFS  = 8'h14;

  // fields of a comparator configuration register
  localparam int unsigned CFG_EN_BIT   = 0;
  localparam int unsigned CFG_POS_BIT  = 1;
  localparam int unsigned CFG_NREF_BIT = 2;
  localparam int unsigned CFG_PIN_BIT  = 3;
  localparam int unsigned CFG_FLAG_BIT = 4;
  localparam int unsigned CFG_RES_BIT  = 5;
  localparam int unsigned CFG_SET_BIT  = 6;

  // reference select fields and power control bit
  localparam int unsigned REF0_LSB    = 0;
  localparam int unsigned REF1_LSB    = 4;
  localparam int unsigned PWR_OFF_BIT = 5;

  // values after reset
  localparam logic [3:0] CFG_RST  = 4'h0;
  localparam logic [7:0] REF_RST  = 8'h00;
  localparam logic [7:0] PWR_RST  = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // settling time, counted in core clock cycles, rounded up
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SETTLE_NS     = 10000;
  localparam int unsigned SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETTLE_W      = 10;

endpackage

// File: cmp_channel.sv
// one comparator: result sampling, change detection and settle timer
`timescale 1ns/1ps
module cmp_channel (
  input  wire  logic core_clk,  // core clock
  input  wire  logic rst,       // async reset, active high
  input  wire  logic on,        // comparator effectively enabled
  input  wire  logic raw,       // analog decision, synchronous
  output logic       result_r,  // sampled result
  output logic       settled_r, // settle time has passed
  output logic       change     // result differs from previous sample, outside settling
);
  import cmp_pkg::*;

  localparam logic [SETTLE_W-1:0] SETTLE_MAX = SETTLE_W'(SETTLE_CYC);

  logic                prev_r;
  logic [SETTLE_W-1:0] cnt_r;

  // sample once per clock; a switched-off comparator reads high
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      result_r <= 1'b1;
      prev_r   <= 1'b1;
    end else begin
      result_r <= on ? raw : 1'b1;
      prev_r   <= result_r;
    end
  end

  // settle timer restarts on every enable
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt_r     <= '0;
      settled_r <= 1'b0;
    end else if (!on) begin
      cnt_r     <= '0;
      settled_r <= 1'b0;
    end else if (cnt_r != SETTLE_MAX) begin
      cnt_r     <= cnt_r + 1'b1;
      settled_r <= 1'b0;
    end else begin
      settled_r <= 1'b1;
    end
  end

  // changes while still settling are noise; the disable edge is kept
  assign change = (result_r != prev_r) && !(on && !settled_r);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  settle_low_a: assert property ($rose(on) |=> !settled_r [*8])
    else $error("settled raised too early");
  settle_cnt_a: assert property (settled_r |-> cnt_r == SETTLE_MAX)
    else $error("settled without full count");
  forced_high_a: assert property (!on |=> result_r)
    else $error("disabled comparator not high");

endmodule

// File: dual_comparator_control.sv
// top of the comparator block: bus slave, registers, flags, interrupt and analog controls
`timescale 1ns/1ps
module dual_comparator_control (
  input  wire  logic                      core_clk,        // core clock, 100 MHz
  input  wire  logic                      rst,             // async reset, active high
  // axi4-lite write address
  input  wire  logic [cmp_pkg::ADDR_W-1:0] s_axi_awaddr,   // write address
  input  wire  logic                      s_axi_awvalid,   // write address valid
  output logic                            s_axi_awready,   // write address ready
  // axi4-lite write data
  input  wire  logic [31:0]               s_axi_wdata,     // write data
  input  wire  logic [3:0]                s_axi_wstrb,     // byte strobes
  input  wire  logic                      s_axi_wvalid,    // write data valid
  output logic                            s_axi_wready,    // write data ready
  // axi4-lite write response
  output logic [1:0]                      s_axi_bresp,     // write answer
  output logic                            s_axi_bvalid,    // write answer valid
  input  wire  logic                      s_axi_bready,    // write answer ready
  // axi4-lite read
  input  wire  logic [cmp_pkg::ADDR_W-1:0] s_axi_araddr,   // read address
  input  wire  logic                      s_axi_arvalid,   // read address valid
  output logic                            s_axi_arready,   // read address ready
  output logic [31:0]                     s_axi_rdata,     // read data
  output logic [1:0]                      s_axi_rresp,     // read answer
  output logic                            s_axi_rvalid,    // read data valid
  input  wire  logic                      s_axi_rready,    // read data ready
  // power mode inputs from the power manager
  input  wire  logic                      idle_mode,       // processor idle
  input  wire  logic                      pwrdn_mode,      // power-down
  input  wire  logic                      total_pwrdn,     // total power-down
  // analog side
  input  wire  logic [1:0]                cmp_raw,         // decisions per comparator
  output logic [1:0]                      cmp_on_r,        // bias on per comparator
  output logic [1:0]                      pos_sel_r,       // positive pin choice
  output logic [1:0]                      neg_ref_r,       // negative from reference
  output logic [2:0]                      ref_level0_r,    // reference level, cmp 0
  output logic [2:0]                      ref_level1_r,    // reference level, cmp 1
  output logic [1:0]                      result_pin_r,    // result to pin
  output logic [1:0]                      result_pin_oe_r, // result pin drive
  // processor side
  output logic                            irq_r,           // shared interrupt, level
  output logic                            wake_r           // wake from idle/power-down
);
  import cmp_pkg::*;

  // write channel state
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0]       w_data_r;
  logic [3:0]        w_strb_r;
  logic              wr_go;
  logic              wr_hit;

  // register state
  logic [3:0]        cfg_r [N_CMP];
  logic [7:0]        ref_r;
  logic [7:0]        pwr_r;
  logic [1:0]        mask_r;
  logic [1:0]        flag_r;
  logic [1:0]        flag_nxt;
  logic              tpd_prev_r;

  // per comparator wires
  logic [1:0]        result;
  logic [1:0]        settled;
  logic [1:0]        change;
  logic [1:0]        on;

  // read decode
  logic [31:0]       rd_data_nxt;
  logic              rd_hit;

  // a write happens once both halves are held and no answer is pending
  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  // write address and data are taken independently, in any order
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      aw_addr_r     <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_addr_r     <= s_axi_awaddr;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_wready <= 1'b1;
      w_data_r     <= '0;
      w_strb_r     <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_data_r     <= s_axi_wdata;
      w_strb_r     <= s_axi_wstrb;
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_wready <= 1'b1;
    end
  end

  // known offsets answer okay, anything else slave error
  always_comb begin
    case (aw_addr_r)
      CFG0_OFS, CFG1_OFS, REF_OFS, STAT_OFS, MASK_OFS, PWR_OFS: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write answer one cycle after both halves are in
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // register writes; only the low byte lane carries fields
  logic wr_lo;
  assign wr_lo = wr_go && w_strb_r[0];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_r  <= REF_RST;
      pwr_r  <= PWR_RST;
      mask_r <= MASK_RST;
    end else begin
      if (wr_lo && aw_addr_r == REF_OFS) begin
        ref_r <= w_data_r[7:0];
      end
      if (wr_lo && aw_addr_r == PWR_OFS) begin
        pwr_r <= w_data_r[7:0];
      end
      if (wr_lo && aw_addr_r == MASK_OFS) begin
        mask_r <= w_data_r[1:0];
      end
    end
  end

  // edge of total power-down entry
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tpd_prev_r <= 1'b0;
    end else begin
      tpd_prev_r <= total_pwrdn;
    end
  end

  // per comparator: configuration, channel, flag and analog controls
  for (genvar i = 0; i < N_CMP; i++) begin : g_cmp
    logic [7:0] cfg_ofs;
    logic       wr_cfg;
    logic       clr;

    assign cfg_ofs = (i == 0) ? CFG0_OFS : CFG1_OFS;
    assign wr_cfg  = wr_lo && aw_addr_r == cfg_ofs;

    // entry to total power-down wins over a software write
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cfg_r[i] <= CFG_RST;
      end else if (total_pwrdn && !tpd_prev_r) begin
        cfg_r[i][CFG_EN_BIT] <= 1'b0;
      end else if (wr_cfg) begin
        cfg_r[i] <= w_data_r[3:0];
      end
    end

    // effective enable: off bit and total power-down override software
    assign on[i] = cfg_r[i][CFG_EN_BIT] && !pwr_r[PWR_OFF_BIT] &&
                   !total_pwrdn;

    cmp_channel u_chan (
      .core_clk  (core_clk),
      .rst       (rst),
      .on        (on[i]),
      .raw       (cmp_raw[i]),
      .result_r  (result[i]),
      .settled_r (settled[i]),
      .change    (change[i])
    );

    // flag clears by zero in the config register or one in the status register
    assign clr = (wr_cfg && !w_data_r[CFG_FLAG_BIT]) ||
                 (wr_lo && aw_addr_r == STAT_OFS && w_data_r[i]);
    // a change in the clearing cycle is kept
    assign flag_nxt[i] = change[i] || (flag_r[i] && !clr);

    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        flag_r[i] <= 1'b0;
      end else begin
        flag_r[i] <= flag_nxt[i];
      end
    end

    // analog and pin controls, registered so the outputs are glitch free
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        cmp_on_r[i]        <= 1'b0;
        pos_sel_r[i]       <= 1'b0;
        neg_ref_r[i]       <= 1'b0;
        result_pin_r[i]    <= 1'b1;
        result_pin_oe_r[i] <= 1'b0;
      end else begin
        cmp_on_r[i]        <= on[i];
        pos_sel_r[i]       <= cfg_r[i][CFG_POS_BIT];
        neg_ref_r[i]       <= cfg_r[i][CFG_NREF_BIT];
        result_pin_r[i]    <= result[i];
        result_pin_oe_r[i] <= cfg_r[i][CFG_PIN_BIT];
      end
    end

    // result pin follows the sampled result one cycle later
    pin_route_a: assert property (@(posedge core_clk) disable iff (rst)
      result_pin_r[i] == $past(result[i]))
      else $error("pin does not follow result");

    // a rising result outside settling sets the flag
    change_flag_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(result[i]) && !(on[i] && !settled[i]) |=> flag_r[i])
      else $error("result change lost");

    // a reported change always lands in the flag, even against a clear
    flag_set_a: assert property (@(posedge core_clk) disable iff (rst)
      change[i] |=> flag_r[i])
      else $error("change flag not set");
  end

  // each comparator picks its own reference level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ref_level0_r <= '0;
      ref_level1_r <= '0;
    end else begin
      ref_level0_r <= ref_r[REF0_LSB +: REF_W];
      ref_level1_r <= ref_r[REF1_LSB +: REF_W];
    end
  end

  // shared interrupt and wake; total power-down blocks the wake
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      irq_r  <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r  <= |(flag_r & mask_r);
      wake_r <= |(flag_r & mask_r) && !total_pwrdn && (idle_mode || pwrdn_mode);
    end
  end

  // read data view; reserved bits read zero
  always_comb begin
    rd_data_nxt = '0;
    rd_hit      = 1'b1;
    case (s_axi_araddr)
      CFG0_OFS: begin
        rd_data_nxt[3:0]          = cfg_r[0];
        rd_data_nxt[CFG_FLAG_BIT] = flag_r[0];
        rd_data_nxt[CFG_RES_BIT]  = result[0];
        rd_data_nxt[CFG_SET_BIT]  = settled[0];
      end
      CFG1_OFS: begin
        rd_data_nxt[3:0]          = cfg_r[1];
        rd_data_nxt[CFG_FLAG_BIT] = flag_r[1];
        rd_data_nxt[CFG_RES_BIT]  = result[1];
        rd_data_nxt[CFG_SET_BIT]  = settled[1];
      end
      REF_OFS:  rd_data_nxt[7:0] = ref_r;
      STAT_OFS: rd_data_nxt[1:0] = flag_r;
      MASK_OFS: rd_data_nxt[1:0] = mask_r;
      PWR_OFS:  rd_data_nxt[7:0] = pwr_r;
      default:  rd_hit = 1'b0;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_data_nxt;
      s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  sequence r_give;
    s_axi_rvalid && !s_axi_arready;
  endsequence

  sequence aw_w_held;
    !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  endsequence

  read_lat_a: assert property (ar_take |=> r_give)
    else $error("read answer not one cycle after address");

  write_resp_a: assert property (aw_w_held |=> s_axi_bvalid ##0 !s_axi_awready)
    else $error("write answer missing");

  strb_gate_a: assert property (wr_go && !w_strb_r[0] |=>
    $stable(ref_r) && $stable(pwr_r) && $stable(mask_r))
    else $error("write without low lane strobe changed a register");

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");

  // interrupt level checked in both directions, one cycle behind the flags
  irq_or_a: assert property (|(flag_r & mask_r) |=> irq_r)
    else $error("interrupt not OR of enabled flags");

  irq_low_a: assert property (!(|(flag_r & mask_r)) |=> !irq_r)
    else $error("interrupt without enabled flag");

  wake_gate_a: assert property (total_pwrdn |=> !wake_r)
    else $error("wake during total power-down");

  tpd_off_a: assert property (total_pwrdn |=> cmp_on_r == 2'h0)
    else $error("comparator on in total power-down");

  pwr_off_a: assert property (pwr_r[PWR_OFF_BIT] |=> cmp_on_r == 2'h0)
    else $error("comparator on while switched off");

  tpd_clear_a: assert property ($rose(total_pwrdn) |=>
    !cfg_r[0][CFG_EN_BIT] && !cfg_r[1][CFG_EN_BIT])
    else $error("enable kept over total power-down entry");

endmodule

// File: analog_front_model.sv
// behavioural model of the analog pins, reference ladder and both comparator cores
`timescale 1ns/1ps
module analog_front_model #(
  parameter int unsigned REF_STEP_MV = 100  // ladder step, level k gives (k+1) steps
) (
  input  wire logic        core_clk, // core clock
  input  wire logic [1:0]  on,       // bias on per comparator
  input  wire logic [1:0]  pos_sel,  // positive pin choice
  input  wire logic [1:0]  neg_ref,  // negative input from reference
  input  wire logic [2:0]  lvl0,     // reference level, cmp 0
  input  wire logic [2:0]  lvl1,     // reference level, cmp 1
  input  wire logic [11:0] pin_a [2], // first positive pin, mV
  input  wire logic [11:0] pin_b [2], // second positive pin, mV
  input  wire logic [11:0] pin_n [2], // negative pin, mV
  output logic      [1:0]  raw       // decision per comparator
);
  logic [1:0] junk_r = 2'h1;

  // an unbiased core decides nothing: show a moving pattern, never a held value
  always_ff @(posedge core_clk) junk_r <= ~junk_r;

  // pick inputs, build the reference and compare
  always_comb begin
    int vp;
    int vn;
    vp = 0;
    vn = 0;
    for (int i = 0; i < 2; i++) begin
      vp = pos_sel[i] ? int'(pin_b[i]) : int'(pin_a[i]);
      vn = (int'(i == 0 ? lvl0 : lvl1) + 1) * REF_STEP_MV;
      if (!neg_ref[i]) vn = int'(pin_n[i]);
      raw[i] = on[i] ? (vp > vn) : junk_r[i];
    end
  end
endmodule

// File: test_dual_comparator_control.sv
// self-checking bench: registers, flags, interrupt and power modes of the comparator block
`timescale 1ns/1ps
module test_dual_comparator_control;
  import cmp_pkg::*;
  logic        core_clk = 0;
  logic        rst      = 1;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs, cmp_raw, cmp_on_r, pos_sel_r, neg_ref_r;
  logic [1:0]  result_pin_r, result_pin_oe_r;
  logic [2:0]  ref_level0_r, ref_level1_r;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        idle_mode, pwrdn_mode, total_pwrdn, irq_r, wake_r;
  logic [11:0] pin_a [2];
  logic [11:0] pin_b [2];
  logic [11:0] pin_n [2];
  int          n_errors = 0;
  int          compares = 0;

  always #5 core_clk = ~core_clk;

  dual_comparator_control dut_u (.core_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .idle_mode, .pwrdn_mode,
    .total_pwrdn, .cmp_raw, .cmp_on_r, .pos_sel_r, .neg_ref_r, .ref_level0_r, .ref_level1_r,
    .result_pin_r, .result_pin_oe_r, .irq_r, .wake_r);

  analog_front_model front_u (.core_clk, .on(cmp_on_r), .pos_sel(pos_sel_r),
    .neg_ref(neg_ref_r), .lvl0(ref_level0_r), .lvl1(ref_level1_r), .pin_a, .pin_b, .pin_n,
    .raw(cmp_raw));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // address and data offered together, each released when taken; answer readies stay high
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(ad && dd)) begin
      @(posedge core_clk);
      ad |= (s_axi_awready === 1'b1);
      dd |= (s_axi_wready === 1'b1);
      if (ad) s_axi_awvalid <= 1'b0;
      if (dd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
  endtask

  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic wchk(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rs);
    chk(32'(rs), 32'(RESP_OKAY));
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    rdr(a, rd, rs);
    chk(rd & m, e);
    chk(32'(rs), 32'(RESP_OKAY));
  endtask

  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the sequence needs about 2200 cycles
  initial begin
    cyc(20000);
    n_errors++;
    wrap_up();
  end

  // main sequence
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {idle_mode, pwrdn_mode, total_pwrdn} = '0;
    pin_a = '{12'd100, 12'd350};
    pin_b = '{12'd0, 12'd900};
    pin_n = '{12'd300, 12'd0};
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    for (int i = 0; i < 6; i++) rchk(8'(4 * i), i < 2 ? 32'h20 : '0, 32'hFFFF_FFBF);
    rdr(8'h18, rd, rs);
    chk(rd, 32'h0000_0000);
    chk(32'(rs), 32'(RESP_SLVERR));
    wr(8'h18, 32'h0000_00FF, rs);
    chk(32'(rs), 32'(RESP_SLVERR));
    // a write without the low lane strobe is answered but changes nothing
    s_axi_wstrb <= 4'h0;
    wchk(REF_OFS, 32'h0000_0077);
    s_axi_wstrb <= 4'hF;
    rchk(REF_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    chk(32'(result_pin_r), 32'h0000_0003);
    // enable with a low decision: the drop inside the settle time is not a change
    wchk(CFG0_OFS, 32'h0000_0009);
    cyc(3);
    chk(32'({cmp_on_r[0], result_pin_oe_r[0]}), 32'h0000_0003);
    cyc(1010);
    rchk(STAT_OFS, 32'h0000_0000, 32'hFFFF_FFFF);
    rchk(CFG0_OFS, 32'h0000_0049, 32'hFFFF_FFFF);
    chk(32'(result_pin_r[0]), 32'h0000_0000);
    // a settled change sets the flag; the interrupt follows the mask
    pin_a[0] <= 12'd500;
    cyc(4);
    rchk(STAT_OFS, 32'h0000_0001, 32'hFFFF_FFFF);
    chk(32'(irq_r), 32'h0000_0000);
    wchk(MASK_OFS, 32'h0000_0001);
    cyc(2);
    chk(32'(irq_r), 32'h0000_0001);
    idle_mode <= 1'b1;
    cyc(2);
    chk(32'({wake_r, cmp_on_r[0]}), 32'h0000_0003);
    wchk(STAT_OFS, 32'h0000_0001);
    cyc(2);
    chk(32'(irq_r), 32'h0000_0000);
    pin_a[0] <= 12'd100;
    cyc(4);
    chk(32'(irq_r), 32'h0000_0001);
    wchk(CFG0_OFS, 32'h0000_0009);
    cyc(2);
    chk(32'(irq_r), 32'h0000_0000);
    // power-off bit with a low result: forced high and reported as a change
    wchk(PWR_OFS, 32'h0000_0020);
    cyc(3);
    chk(32'({cmp_on_r[0], result_pin_r[0], irq_r}), 32'h0000_0003);
    rchk(STAT_OFS, 32'h0000_0001, 32'hFFFF_FFFF);
    rchk(PWR_OFS, 32'h0000_0020, 32'hFFFF_FFFF);
    wchk(PWR_OFS, 32'h0000_0000);
    wchk(MASK_OFS, 32'h0000_0000);
    wchk(STAT_OFS, 32'h0000_0003);
    // second comparator against every reference level, first one on the mirror level
    wchk(CFG1_OFS, 32'h0000_0005);
    cyc(1010);
    for (int k = 0; k < 8; k++) begin
      wchk(REF_OFS, 32'((k << 4) | (7 - k)));
      cyc(3);
      chk(32'({ref_level1_r, ref_level0_r}), 32'((k << 3) | (7 - k)));
      rdr(CFG1_OFS, rd, rs);
      chk(32'(rd[5]), 32'(350 > (k + 1) * 100));
    end
    wchk(CFG1_OFS, 32'h0000_0007);
    cyc(3);
    rdr(CFG1_OFS, rd, rs);
    chk(32'({pos_sel_r[1], neg_ref_r[1], rd[5]}), 32'h0000_0007);
    // power-down wakes on a pending flag; total power-down disables both
    idle_mode  <= 1'b0;
    pwrdn_mode <= 1'b1;
    wchk(MASK_OFS, 32'h0000_0003);
    cyc(2);
    chk(32'({irq_r, wake_r}), 32'h0000_0003);
    total_pwrdn <= 1'b1;
    cyc(3);
    chk(32'({cmp_on_r, wake_r}), 32'h0000_0000);
    rdr(CFG0_OFS, rd, rs);
    chk(32'(rd[0]), 32'h0000_0000);
    rdr(CFG1_OFS, rd, rs);
    chk(32'(rd[0]), 32'h0000_0000);
    wrap_up();
  end
endmodule
